// ===== rtl/eps_pkg.sv
`default_nettype none
package eps_pkg;
	// Frame layout
	localparam int unsigned COORD_BITS = 8;
	localparam int unsigned FRAME_BITS = 16;
	// Reset values of the serial pins and the bit counter
	localparam logic RST_STROBE_N = 1'h1;
	localparam logic RST_DATA = 1'h0;
	localparam logic [4:0] RST_BIT_CNT = 5'h00;
	// Gap state length after each frame, in shift clock periods; the strobe stays high at least one period more
	localparam logic [1:0] GAP_PERIODS = 2'h1;

	typedef struct packed {
		logic [7:0] x;
		logic [7:0] y;
	} eps_sample_t;
endpackage
`default_nettype wire

// ===== rtl/eps_eye_serial.sv
// Functional notes
// - Each sample leaves as one 16-bit serial frame built from two 8-bit coordinates.
// - The horizontal byte goes out first, then the vertical byte.
// - Each byte goes out low bit first by default; a parameter selects high bit first.
// - One new bit is driven on each of the first 16 rising edges of a frame of the 1.536 MHz shift clock.
// - The strobe stays low for the whole frame; the receiver trusts data only then.
// - The strobe only changes on rising edges of the shift clock.
`default_nettype none
module eps_eye_serial #(
	parameter bit LSB_FIRST = 1'b1
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic eye_shift_clock,
	input wire eps_pkg::eps_sample_t sample_data,
	input wire logic sample_valid,
	output logic sample_ready,
	output logic eye_data,
	output logic eye_frame_strobe_n
);
	typedef enum logic [1:0] {EPS_IDLE, EPS_SHIFT, EPS_GAP} eps_state_t;

	// ****************************************
	// Shift clock edge detect
	// ****************************************
	// The shift clock is an unrelated pin: three flops, and a level
	// only counts once the second and third stages agree, so a
	// metastable first stage cannot fake an edge.
	logic [2:0] sclk_sync_reg;
	logic sclk_level_reg;
	logic sclk_rise;

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			sclk_sync_reg <= 3'h0;
		end else begin
			sclk_sync_reg <= {sclk_sync_reg[1:0], eye_shift_clock};
		end
	end

	// Filtered level resets to the idle level of the pin
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			sclk_level_reg <= 1'b0;
		end else if (sclk_sync_reg[1] == sclk_sync_reg[2]) begin
			sclk_level_reg <= sclk_sync_reg[2];
		end
	end

	assign sclk_rise = sclk_sync_reg[1] & sclk_sync_reg[2] &
		~sclk_level_reg;

	// ****************************************
	// Frame sequencer
	// ****************************************
	eps_state_t state_reg;
	logic [15:0] shift_reg;
	logic [4:0] bit_cnt_reg;
	logic [1:0] gap_cnt_reg;
	logic [15:0] frame_next;

	// Reorders bits of a byte when high bit first is chosen
	function automatic logic [7:0] eps_order(input logic [7:0] b);
		logic [7:0] r;
		r = b;
		if (!LSB_FIRST) begin
			for (int i = 0; i < 8; i++) begin
				r[i] = b[7 - i];
			end
		end
		return r;
	endfunction

	// Shift register sends bit 0 first; X occupies the low byte
	assign frame_next = {eps_order(sample_data.y),
		eps_order(sample_data.x)};

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			state_reg <= EPS_IDLE;
			shift_reg <= 16'h0000;
			bit_cnt_reg <= eps_pkg::RST_BIT_CNT;
			gap_cnt_reg <= 2'h0;
			eye_data <= eps_pkg::RST_DATA;
			eye_frame_strobe_n <= eps_pkg::RST_STROBE_N;
			sample_ready <= 1'b0;
		end else begin
			sample_ready <= 1'b0;
			// All pin changes wait for a shift clock rising edge
			if (sclk_rise) begin
				unique case (state_reg)
					EPS_IDLE: begin
						if (sample_valid) begin
							shift_reg <= {1'b0, frame_next[15:1]};
							eye_data <= frame_next[0];
							eye_frame_strobe_n <= 1'b0;
							bit_cnt_reg <= 5'h01;
							sample_ready <= 1'b1;
							state_reg <= EPS_SHIFT;
						end
					end
					EPS_SHIFT: begin
						if (bit_cnt_reg == 5'(eps_pkg::FRAME_BITS)) begin
							// Sixteen bits out: release strobe
							eye_frame_strobe_n <= 1'b1;
							eye_data <= eps_pkg::RST_DATA;
							gap_cnt_reg <= eps_pkg::GAP_PERIODS;
							state_reg <= EPS_GAP;
						end else begin
							eye_data <= shift_reg[0];
							shift_reg <= {1'b0, shift_reg[15:1]};
							bit_cnt_reg <= bit_cnt_reg + 5'h01;
						end
					end
					EPS_GAP: begin
						// Strobe held high at least one full period
						if (gap_cnt_reg == 2'h1) begin
							state_reg <= EPS_IDLE;
						end
						gap_cnt_reg <= gap_cnt_reg - 2'h1;
					end
					default: begin
						state_reg <= EPS_IDLE;
					end
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// ===== dv/eps_eye_serial_properties.sv
`default_nettype none
module eps_chk(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic eye_shift_clock,
	input wire eps_pkg::eps_sample_t sample_data,
	input wire logic sample_ready,
	input wire logic eye_data,
	input wire logic eye_frame_strobe_n
);
	logic ck_reg;
	logic [3:0] age_reg;
	// Cycles since the last shift clock rise, saturating
	always_ff @(posedge clk_sys) begin
		ck_reg <= eye_shift_clock;
		if (sys_rst) age_reg <= 4'hF;
		else if (eye_shift_clock && !ck_reg) age_reg <= 4'h0;
		else if (age_reg != 4'hF) age_reg <= age_reg + 4'h1;
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	AST_RDY: assert property (sample_ready |-> !eye_frame_strobe_n)
		else $error("ready outside frame");
	AST_FIRST: assert property ($fell(eye_frame_strobe_n) |->
		eye_data == $past(sample_data.x[0])) else $error("first bit wrong");
	AST_DATA: assert property ($changed(eye_data) |-> age_reg <= 4'h5)
		else $error("data moved off edge");
	AST_LOW: assert property ($fell(eye_frame_strobe_n) |->
		!eye_frame_strobe_n [*8]) else $error("frame cut");
	AST_STB: assert property ($changed(eye_frame_strobe_n) |->
		age_reg <= 4'h5) else $error("strobe moved off edge");
	AST_LEN: assert property ($fell(eye_frame_strobe_n) |->
		##120 !eye_frame_strobe_n) else $error("frame short");
	AST_GAP: assert property ($rose(eye_frame_strobe_n) |->
		eye_frame_strobe_n [*8]) else $error("gap short");
endmodule
bind eps_eye_serial eps_chk chk_u(.*);
`default_nettype wire

// ===== dv/eps_dac.sv
`default_nettype none
module eps_dac(
	input wire logic eye_shift_clock,
	input wire logic eye_data,
	input wire logic eye_frame_strobe_n,
	output logic [15:0] word,
	output int n_words
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] sr = '0;
	int nb = 0;
	initial n_words = 0;
	always @(negedge eye_shift_clock) if (!eye_frame_strobe_n) begin
		sr = {eye_data, sr[15:1]};
		nb++;
	end
	always @(posedge eye_frame_strobe_n) if (nb != 0) begin
		word = sr;
		nb = 0;
		n_words++;
	end
endmodule
`default_nettype wire

// ===== dv/eps_eye_serial_test.sv
`default_nettype none
module eps_eye_serial_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 0, sys_rst = 1, eye_shift_clock = 0, sample_valid = 0;
	eps_pkg::eps_sample_t sample_data = '0;
	logic sample_ready, eye_data, eye_frame_strobe_n;
	logic [15:0] word;
	logic [31:0] lf = 32'h2E17B47E;
	logic [15:0] q[$];
	int n_words, n_errors = 0, n_compared = 0, k;
	eps_eye_serial dut_u(.*);
	eps_dac dac_u(.*);
	function logic [31:0] nx(logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task chk(string nm, logic [15:0] e, logic [15:0] s);
		n_compared++;
		if (s !== e) begin
			$display("[FAIL] %s exp %h got %h", nm, e, s);
			n_errors++;
		end
	endtask
	task end_of_test;
		if (n_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	initial forever #4 clk_sys = ~clk_sys;
	initial #13 forever #32 eye_shift_clock = ~eye_shift_clock;
	always @(n_words) chk("word", q.pop_front(), word);
	initial begin
		repeat (6) @(negedge clk_sys);
		sys_rst = 0;
		sample_valid = 1;
		repeat (12) begin
			lf = nx(lf);
			sample_data = lf[15:0];
			k = 0;
			do @(negedge clk_sys) k++; while (!sample_ready && k < 999);
			if (k == 999) begin
				n_errors++;
				end_of_test;
			end
			q.push_back({sample_data.y, sample_data.x});
		end
		sample_valid = 0;
		repeat (600) @(negedge clk_sys);
		chk("left", 16'h0000, 16'(q.size()));
		end_of_test;
	end
endmodule
`default_nettype wire
